//--- verilog/lpddr2_mr_pkg.sv
package lpddr2_mr_pkg;
    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_DEV_INFO  = 8'h00;
    localparam logic [7:0] IDX_FEAT_ONE  = 8'h01;
    localparam logic [7:0] IDX_FEAT_TWO  = 8'h02;
    localparam logic [7:0] IDX_IO_CFG    = 8'h03;
    localparam logic [7:0] IDX_REFRESH   = 8'h04;
    localparam logic [7:0] IDX_MAKER     = 8'h05;
    localparam logic [7:0] IDX_REV_ONE   = 8'h06;
    localparam logic [7:0] IDX_REV_TWO   = 8'h07;
    localparam logic [7:0] IDX_BASIC_CFG = 8'h08;
    localparam logic [7:0] IDX_TEST_MODE = 8'h09;
    localparam logic [7:0] IDX_ZQ_CMD    = 8'h0a;
    localparam logic [7:0] IDX_BANK_MASK = 8'h10;
    localparam logic [7:0] IDX_SEG_MASK  = 8'h11;
    localparam logic [7:0] IDX_PATTERN_A = 8'h20;
    localparam logic [7:0] IDX_PATTERN_B = 8'h28;
    localparam logic [7:0] IDX_RESET     = 8'h3f;
    // ----------------------------------------------------------------
    // Field positions, codes and reset values
    // ----------------------------------------------------------------
    localparam int         POS_AUTO_INIT = 0;
    localparam int         POS_KIND      = 1;
    localparam int         POS_VALIDITY  = 2;
    localparam int         POS_ZQ_LO     = 3;
    localparam logic [2:0] BURST_CODE_4  = 3'h2;
    localparam logic [2:0] BURST_CODE_8  = 3'h3;
    localparam logic [2:0] BURST_CODE_16 = 3'h4;
    localparam logic [4:0] BEATS_4       = 5'h04;
    localparam logic [4:0] BEATS_8       = 5'h08;
    localparam logic [4:0] BEATS_16      = 5'h10;
    localparam logic [2:0] WR_CODE_MIN   = 3'h1;
    localparam logic [2:0] WR_CODE_MAX   = 3'h6;
    localparam logic [3:0] WR_OFFSET     = 4'h2;
    localparam logic [7:0] FEAT_ONE_RST  = 8'h22;
    localparam logic [3:0] LOW_NIB_RST   = 4'h0;
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam logic [1:0] ZQ_NONE       = 2'h0;
    localparam logic [1:0] ZQ_TIED_SUPPLY = 2'h1;
    localparam logic [1:0] ZQ_TO_GROUND  = 2'h2;
    localparam logic [7:0] ZQ_INIT_CODE  = 8'hff;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int AUTO_INIT_MAX_NS = 10000;
    localparam int ZQ_INIT_MIN_NS   = 1000;
    localparam int CLK_PERIOD_NS    = 100;
    localparam int AUTO_INIT_CYC    = AUTO_INIT_MAX_NS / CLK_PERIOD_NS;
    localparam int ZQ_INIT_CYC      = (ZQ_INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AI_CNT_W         = 7;
    localparam int ZQ_CNT_W         = 4;
    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic [7:0] registerIndex;
        logic [7:0] opcode;
    } mrCmd_t;
    typedef struct packed {
        logic [4:0] burstBeats;
        logic       burstTypeField;
        logic       wrapControlField;
        logic [3:0] writeRecoveryCycles;
        logic [3:0] readWriteLatencyField;
        logic [3:0] driveStrengthField;
        logic [7:0] partialRefreshBankMask;
        logic [7:0] partialRefreshSegmentMask;
        logic [7:0] testModeCode;
    } featureCfg_t;
endpackage : lpddr2_mr_pkg

//--- verilog/lpddr2_mode_register_bank.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Access only through register read and write commands.
// - Provides configuration, status and special-operation triggers.
// - Reserved bits always read back as zero.
// - Unreadable registers still strobe; data reads zero.
// - Writes to read-only registers change nothing.
// - Info register read-only with four fields.
// - Busy bit during auto-init; kind bit for nonvolatile.
// - Data-validity bit reads zero.
// - Self-test field encodes four resistor outcomes.
// - Self-test field updates when init calibration completes.
// - Assembly error: factory trim, calibration ignored.
// - Feature-one register write-only, four fields.
// - Burst codes give 4, 8, 16 beats.
// - Two read-only calibration pattern registers.
// - Write-recovery codes give 3 to 8 cycles.
module lpddr2_mode_register_bank #(
    parameter logic       SELF_TEST_EN = 1'b1,
    parameter logic       NONVOLATILE  = 1'b0,
    parameter logic [7:0] MAKER_CODE   = 8'h01, // Arbitrary value.
    parameter logic [7:0] REV_CODE_ONE = 8'h00, // Arbitrary value.
    parameter logic [7:0] REV_CODE_TWO = 8'h00, // Arbitrary value.
    parameter logic [7:0] BASIC_CODE   = 8'h00, // Arbitrary value.
    parameter logic [7:0] PATTERN_A    = 8'h55,
    parameter logic [7:0] PATTERN_B    = 8'h33
) (
    input  wire logic                        clk_sys,
    input  wire logic                        nrst,
    input  wire logic                        cmdValid,
    input  wire lpddr2_mr_pkg::mrCmd_t       cmdIn,
    output logic                             cmdReady,
    output logic                             rdValid,
    output logic [7:0]                       rdData,
    output logic                             dqsOut,
    input  wire logic [1:0]                  zqSense,
    input  wire logic                        temperatureUpdateFlag,
    input  wire logic [2:0]                  refreshRate,
    output logic                             autoInitBusy,
    output logic                             zqCalBusy,
    output logic                             factoryTrim,
    output lpddr2_mr_pkg::featureCfg_t       cfg
);
    typedef enum logic [0:0] {BURST_IDLE, BURST_RUN} burstState_t;
    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    burstState_t          state_ff, nxt_state;
    logic                 takeRd, takeWr;
    logic [7:0]           idx;
    // Commands are refused while a read burst is still on the strobe.
    assign cmdReady = (state_ff == BURST_IDLE);
    assign takeRd   = cmdValid && cmdReady && !cmdIn.write;
    assign takeWr   = cmdValid && cmdReady && cmdIn.write;
    assign idx      = cmdIn.registerIndex;
    // ----------------------------------------------------------------
    // Resistor sense pins, two-stage synchroniser
    // ----------------------------------------------------------------
    logic [1:0] senseMeta_ff, senseSync_ff;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            senseMeta_ff <= 2'h0;
            senseSync_ff <= 2'h0;
        end else begin
            senseMeta_ff <= zqSense;
            senseSync_ff <= senseMeta_ff;
        end
    end
    // ----------------------------------------------------------------
    // Write-only configuration registers
    // ----------------------------------------------------------------
    logic [7:0] featOne_ff, nxt_featOne;
    logic [3:0] featTwo_ff, nxt_featTwo;
    logic [3:0] ioCfg_ff, nxt_ioCfg;
    logic [7:0] bank_ff, nxt_bank;
    logic [7:0] seg_ff, nxt_seg;
    logic [7:0] test_ff, nxt_test;
    logic       resetWr;
    assign resetWr = takeWr && (idx == lpddr2_mr_pkg::IDX_RESET);
    // A reset write returns every setting to default; reserved upper
    // bits of the nibble registers are never stored.
    always_comb begin
        nxt_featOne = featOne_ff;
        nxt_featTwo = featTwo_ff;
        nxt_ioCfg   = ioCfg_ff;
        nxt_bank    = bank_ff;
        nxt_seg     = seg_ff;
        nxt_test    = test_ff;
        if (resetWr) begin
            nxt_featOne = lpddr2_mr_pkg::FEAT_ONE_RST;
            nxt_featTwo = lpddr2_mr_pkg::LOW_NIB_RST;
            nxt_ioCfg   = lpddr2_mr_pkg::LOW_NIB_RST;
            nxt_bank    = lpddr2_mr_pkg::BYTE_RST;
            nxt_seg     = lpddr2_mr_pkg::BYTE_RST;
            nxt_test    = lpddr2_mr_pkg::BYTE_RST;
        end else if (takeWr) begin
            unique case (idx)
                lpddr2_mr_pkg::IDX_FEAT_ONE:  nxt_featOne = cmdIn.opcode;
                lpddr2_mr_pkg::IDX_FEAT_TWO:  nxt_featTwo = cmdIn.opcode[3:0];
                lpddr2_mr_pkg::IDX_IO_CFG:    nxt_ioCfg = cmdIn.opcode[3:0];
                lpddr2_mr_pkg::IDX_BANK_MASK: nxt_bank = cmdIn.opcode;
                lpddr2_mr_pkg::IDX_SEG_MASK:  nxt_seg = cmdIn.opcode;
                lpddr2_mr_pkg::IDX_TEST_MODE: nxt_test = cmdIn.opcode;
                default: ; // Read-only and reserved targets store nothing.
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            featOne_ff <= lpddr2_mr_pkg::FEAT_ONE_RST;
            featTwo_ff <= lpddr2_mr_pkg::LOW_NIB_RST;
            ioCfg_ff   <= lpddr2_mr_pkg::LOW_NIB_RST;
            bank_ff    <= lpddr2_mr_pkg::BYTE_RST;
            seg_ff     <= lpddr2_mr_pkg::BYTE_RST;
            test_ff    <= lpddr2_mr_pkg::BYTE_RST;
        end else begin
            featOne_ff <= nxt_featOne;
            featTwo_ff <= nxt_featTwo;
            ioCfg_ff   <= nxt_ioCfg;
            bank_ff    <= nxt_bank;
            seg_ff     <= nxt_seg;
            test_ff    <= nxt_test;
        end
    end
    // Decoded settings; a reserved code yields zero so it is visible.
    logic [2:0] wrCode;
    assign wrCode = featOne_ff[7:5];
    always_comb begin
        unique case (featOne_ff[2:0])
            lpddr2_mr_pkg::BURST_CODE_4:  cfg.burstBeats = lpddr2_mr_pkg::BEATS_4;
            lpddr2_mr_pkg::BURST_CODE_8:  cfg.burstBeats = lpddr2_mr_pkg::BEATS_8;
            lpddr2_mr_pkg::BURST_CODE_16: cfg.burstBeats = lpddr2_mr_pkg::BEATS_16;
            default:                   cfg.burstBeats = 5'h00;
        endcase
        cfg.burstTypeField   = featOne_ff[3];
        cfg.wrapControlField = featOne_ff[4];
        if (wrCode >= lpddr2_mr_pkg::WR_CODE_MIN && wrCode <= lpddr2_mr_pkg::WR_CODE_MAX)
            cfg.writeRecoveryCycles = {1'b0, wrCode} + lpddr2_mr_pkg::WR_OFFSET;
        else
            cfg.writeRecoveryCycles = 4'h0;
        cfg.readWriteLatencyField     = featTwo_ff;
        cfg.driveStrengthField        = ioCfg_ff;
        cfg.partialRefreshBankMask    = bank_ff;
        cfg.partialRefreshSegmentMask = seg_ff;
        cfg.testModeCode              = test_ff;
    end

    // ----------------------------------------------------------------
    // Auto-initialisation timer
    // ----------------------------------------------------------------
    logic                         aiBusy_ff, nxt_aiBusy;
    logic [lpddr2_mr_pkg::AI_CNT_W-1:0] aiCnt_ff, nxt_aiCnt;
    // Runs for the longest allowed auto-init time, so a controller that
    // only waits out the timeout never sees the bit still set.
    always_comb begin
        nxt_aiBusy = aiBusy_ff;
        nxt_aiCnt  = aiCnt_ff;
        if (resetWr) begin
            nxt_aiBusy = 1'b1;
            nxt_aiCnt  = '0;
        end else if (aiBusy_ff) begin
            nxt_aiCnt = aiCnt_ff + 1'b1;
            if (aiCnt_ff == lpddr2_mr_pkg::AI_CNT_W'(lpddr2_mr_pkg::AUTO_INIT_CYC - 1))
                nxt_aiBusy = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            aiBusy_ff <= 1'b1;
            aiCnt_ff  <= '0;
        end else begin
            aiBusy_ff <= nxt_aiBusy;
            aiCnt_ff  <= nxt_aiCnt;
        end
    end

    assign autoInitBusy = aiBusy_ff;
    // ----------------------------------------------------------------
    // Impedance calibration and resistor self-test
    // ----------------------------------------------------------------
    logic                         zqBusy_ff, nxt_zqBusy;
    logic                         zqInit_ff, nxt_zqInit;
    logic [lpddr2_mr_pkg::ZQ_CNT_W-1:0] zqCnt_ff, nxt_zqCnt;
    logic [1:0]                   zqRes_ff, nxt_zqRes;
    logic                         zqWr, zqDone;
    assign factoryTrim = (zqRes_ff == lpddr2_mr_pkg::ZQ_TIED_SUPPLY)
                      || (zqRes_ff == lpddr2_mr_pkg::ZQ_TO_GROUND);
    assign zqWr   = takeWr && (idx == lpddr2_mr_pkg::IDX_ZQ_CMD) && !factoryTrim;
    assign zqDone = zqBusy_ff
                 && zqCnt_ff == lpddr2_mr_pkg::ZQ_CNT_W'(lpddr2_mr_pkg::ZQ_INIT_CYC - 1);

    // A new command during a running calibration is dropped.
    always_comb begin
        nxt_zqBusy = zqBusy_ff;
        nxt_zqInit = zqInit_ff;
        nxt_zqCnt  = zqCnt_ff;
        nxt_zqRes  = zqRes_ff;
        if (zqWr && !zqBusy_ff) begin
            nxt_zqBusy = 1'b1;
            nxt_zqInit = (cmdIn.opcode == lpddr2_mr_pkg::ZQ_INIT_CODE);
            nxt_zqCnt  = '0;
        end else if (zqBusy_ff) begin
            nxt_zqCnt = zqCnt_ff + 1'b1;
            if (zqDone) begin
                nxt_zqBusy = 1'b0;
                if (zqInit_ff && SELF_TEST_EN)
                    nxt_zqRes = senseSync_ff;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            zqBusy_ff <= 1'b0;
            zqInit_ff <= 1'b0;
            zqCnt_ff  <= '0;
            zqRes_ff  <= lpddr2_mr_pkg::ZQ_NONE;
        end else begin
            zqBusy_ff <= nxt_zqBusy;
            zqInit_ff <= nxt_zqInit;
            zqCnt_ff  <= nxt_zqCnt;
            zqRes_ff  <= nxt_zqRes;
        end
    end

    assign zqCalBusy = zqBusy_ff;
    // ----------------------------------------------------------------
    // Read path and strobe burst
    // ----------------------------------------------------------------
    logic [7:0] rdData_ff, nxt_rdData, infoByte, readByte;
    logic [4:0] beat_ff, nxt_beat, beats;
    logic       dqs_ff, nxt_dqs;
    logic       fromInfo_ff, nxt_fromInfo;
    // Upper info bits stay zero; validity is unsupported.
    assign infoByte = {3'h0, zqRes_ff, 1'b0, NONVOLATILE, aiBusy_ff};
    // A reserved burst code still strobes the shortest burst.
    assign beats = (cfg.burstBeats == 5'h00) ? lpddr2_mr_pkg::BEATS_4 : cfg.burstBeats;

    always_comb begin
        unique case (idx)
            lpddr2_mr_pkg::IDX_DEV_INFO:  readByte = infoByte;
            lpddr2_mr_pkg::IDX_REFRESH:
                readByte = {temperatureUpdateFlag, 4'h0, refreshRate};
            lpddr2_mr_pkg::IDX_MAKER:     readByte = MAKER_CODE;
            lpddr2_mr_pkg::IDX_REV_ONE:   readByte = REV_CODE_ONE;
            lpddr2_mr_pkg::IDX_REV_TWO:   readByte = REV_CODE_TWO;
            lpddr2_mr_pkg::IDX_BASIC_CFG: readByte = BASIC_CODE;
            lpddr2_mr_pkg::IDX_PATTERN_A: readByte = PATTERN_A;
            lpddr2_mr_pkg::IDX_PATTERN_B: readByte = PATTERN_B;
            default:                      readByte = 8'h00;
        endcase
    end

    always_comb begin
        nxt_state    = state_ff;
        nxt_beat     = beat_ff;
        nxt_rdData   = rdData_ff;
        nxt_dqs      = 1'b0;
        nxt_fromInfo = fromInfo_ff;
        unique case (state_ff)
            BURST_IDLE: begin
                if (takeRd) begin
                    nxt_state    = BURST_RUN;
                    nxt_beat     = beats - 1'b1;
                    nxt_rdData   = readByte;
                    nxt_fromInfo = (idx == lpddr2_mr_pkg::IDX_DEV_INFO);
                end
            end
            BURST_RUN: begin
                nxt_dqs  = !dqs_ff;
                nxt_beat = beat_ff - 1'b1;
                if (beat_ff == 5'h00) begin
                    nxt_state = BURST_IDLE;
                    nxt_dqs   = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_ff    <= BURST_IDLE;
            beat_ff     <= 5'h00;
            rdData_ff   <= 8'h00;
            dqs_ff      <= 1'b0;
            fromInfo_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            beat_ff     <= nxt_beat;
            rdData_ff   <= nxt_rdData;
            dqs_ff      <= nxt_dqs;
            fromInfo_ff <= nxt_fromInfo;
        end
    end

    assign rdValid = (state_ff == BURST_RUN);
    assign rdData  = rdData_ff;
    assign dqsOut  = dqs_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    reset_sets_busy_a: assert property (resetWr |=> autoInitBusy)
        else $error("Reset write did not raise the busy bit.");
    busy_length_a: assert property ($rose(aiBusy_ff) && aiCnt_ff == '0
        |-> ##99 (aiBusy_ff || resetWr) ##1 (!aiBusy_ff || $past(resetWr)))
        else $error("Auto-init busy did not last the set time.");
    ro_write_a: assert property (takeWr && idx == lpddr2_mr_pkg::IDX_DEV_INFO
        |=> $stable(cfg) && $stable(zqRes_ff))
        else $error("Write to read-only register changed state.");
    info_reserved_a: assert property (rdValid && fromInfo_ff
        |-> rdData[7:5] == 3'h0 && !rdData[2])
        else $error("Reserved or validity bit read as one.");
    strobe_toggle_a: assert property (rdValid && beat_ff != 5'h00 |=> dqsOut != $past(dqsOut))
        else $error("Strobe did not toggle during a burst.");
    burst_eight_a: assert property (takeWr && idx == lpddr2_mr_pkg::IDX_FEAT_ONE
        && cmdIn.opcode[2:0] == lpddr2_mr_pkg::BURST_CODE_8
        |=> cfg.burstBeats == lpddr2_mr_pkg::BEATS_8)
        else $error("Burst code for eight beats misdecoded.");
    trim_ignores_cal_a: assert property (factoryTrim && !zqBusy_ff
        |=> !zqBusy_ff)
        else $error("Calibration ran despite factory trim.");
    self_test_update_a: assert property (zqDone && zqInit_ff && SELF_TEST_EN
        |=> zqRes_ff == $past(senseSync_ff))
        else $error("Self-test field not updated at calibration end.");
endmodule : lpddr2_mode_register_bank

//--- verification/mr_controller_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Controller side of the mode register command port
// ----------------------------------------------------------------
module mr_controller_model (
    input  wire logic             clk_sys,
    input  wire logic             cmdReady,
    output logic                  cmdValid,
    output lpddr2_mr_pkg::mrCmd_t cmdIn
);
    // Request lines start idle.
    initial begin
        cmdValid = 1'b0;
        cmdIn = '0;
    end

    // One command, held until taken or 64 falling edges pass; ready is sampled settled at the falling edge.
    // The payload is inverted on release so a stale command never lingers.
    task automatic issue(input logic wr, input logic [7:0] idx, input logic [7:0] op,
                         input logic [1:0] gap);
        int n;
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdIn <= {wr, idx, op};
        @(negedge clk_sys);
        for (n = 0; n < 64 && cmdReady !== 1'b1; n++) @(negedge clk_sys);
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        cmdIn <= ~cmdIn;
    endtask : issue
endmodule : mr_controller_model

//--- verification/tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb;
    // ----------------------------------------------------------------
    // Bench signals and instances
    // ----------------------------------------------------------------
    localparam logic [7:0] PAT_A = 8'hc3;
    localparam logic [7:0] PAT_B = 8'h96;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value.
    logic clk_sys, nrst, cmdValid, cmdReady, rdValid, dqsOut, tempFlag;
    logic autoInitBusy, zqCalBusy, factoryTrim, prevV;
    logic [1:0] zqSense;
    logic [2:0] rate;
    logic [7:0] rdData, want, op;
    lpddr2_mr_pkg::mrCmd_t cmdIn;
    lpddr2_mr_pkg::featureCfg_t cfg;
    logic [7:0] expByte[$];
    int expBeats[$];
    int failures, nCompared, cycles, beatCnt, curBeats, wantBeats, i;

    lpddr2_mode_register_bank #(.NONVOLATILE(1'b1), .MAKER_CODE(MAKER), .PATTERN_A(PAT_A),
        .PATTERN_B(PAT_B)) dut (.clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid),
        .cmdIn(cmdIn), .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData),
        .dqsOut(dqsOut), .zqSense(zqSense), .temperatureUpdateFlag(tempFlag), .refreshRate(rate),
        .autoInitBusy(autoInitBusy), .zqCalBusy(zqCalBusy), .factoryTrim(factoryTrim),
        .cfg(cfg));
    mr_controller_model ctrl (.clk_sys(clk_sys), .cmdReady(cmdReady), .cmdValid(cmdValid),
        .cmdIn(cmdIn));

    // Read notes the expected byte and burst length before the command goes out.
    task automatic rd(input logic [7:0] idx, input logic [7:0] val);
        expByte.push_back(val);
        expBeats.push_back(curBeats);
        ctrl.issue(1'b0, idx, 8'($urandom), 2'($urandom));
    endtask : rd

    // Write returns once its effect has had one edge to land.
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        ctrl.issue(1'b1, idx, val, 2'($urandom));
        @(negedge clk_sys);
    endtask : wr

    // Bounded wait for both busy flags; a hang shows up as a later mismatch.
    task automatic settle();
        for (int k = 0; k < 300 && (autoInitBusy | zqCalBusy) !== 1'b0; k++) @(negedge clk_sys);
    endtask : settle

    function automatic logic [4:0] beatsOf(input logic [2:0] code);
        return (code == 3'h2) ? 5'h04 : (code == 3'h3) ? 5'h08 : (code == 3'h4) ? 5'h10 : 5'h00;
    endfunction : beatsOf

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // Clock and a cycle ceiling well above the several hundred cycles the run needs.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end

    // Burst watcher: settled values at the falling edge, one note per burst.
    always @(negedge clk_sys) begin
        if (rdValid === 1'b1) begin
            if (prevV !== 1'b1) begin
                beatCnt = 0;
                want = (expByte.size() > 0) ? expByte.pop_front() : 8'hxx;
            end
            beatCnt++;
            `CHK(rdData, want)
            `CHK(dqsOut, ~beatCnt[0])
            `CHK(cmdReady, 1'b0)
        end else if (prevV === 1'b1) begin
            // Popped once here: the compare macro evaluates its operands twice.
            wantBeats = (expBeats.size() > 0) ? expBeats.pop_front() : 0;
            `CHK(beatCnt, wantBeats)
        end
        prevV = rdValid;
    end

    initial begin
        nrst = 1'b0;
        zqSense = 2'h0;
        tempFlag = 1'b0;
        rate = 3'h0;
        curBeats = 4;
        i = $urandom(43);
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        `CHK(autoInitBusy, 1'b1)
        rd(8'h00, 8'h03);
        rd(8'h05, MAKER);
        wr(8'h3f, 8'($urandom));
        rd(8'h00, 8'h03);
        settle();
        rd(8'h00, 8'h02);
        wr(8'h00, 8'h1f);
        wr(8'h20, 8'h00);
        rd(8'h00, 8'h02);
        rd(8'h20, PAT_A);
        rd(8'h28, PAT_B);
        // Every burst and recovery code, each followed by a read at that length.
        for (int c = 0; c < 8; c++) begin
            op = {3'(c), 2'($urandom), 3'(7 - c)};
            wr(8'h01, op);
            `CHK(cfg.burstBeats, beatsOf(op[2:0]))
            `CHK(cfg.writeRecoveryCycles, (c > 0 && c < 7) ? 4'(c + 2) : 4'h0)
            `CHK({cfg.wrapControlField, cfg.burstTypeField}, op[4:3])
            curBeats = (beatsOf(op[2:0]) == 5'h00) ? 4 : int'(beatsOf(op[2:0]));
            @(posedge clk_sys);
            tempFlag <= 1'($urandom);
            rate <= 3'($urandom);
            @(negedge clk_sys);
            rd(8'h04, {tempFlag, 4'h0, rate});
        end
        op = {4'h0, 4'($urandom)};
        wr(8'h02, op);
        `CHK(cfg.readWriteLatencyField, op[3:0])
        wr(8'h03, op);
        `CHK(cfg.driveStrengthField, op[3:0])
        op = 8'($urandom);
        wr(8'h10, op);
        `CHK(cfg.partialRefreshBankMask, op)
        wr(8'h11, ~op);
        `CHK(cfg.partialRefreshSegmentMask, ~op)
        wr(8'h09, op);
        `CHK(cfg.testModeCode, op)
        rd(8'h02, 8'h00);
        rd(8'h0b, 8'h00);
        wr(8'h3f, 8'($urandom));
        `CHK({autoInitBusy, cfg.burstBeats, cfg.writeRecoveryCycles}, 10'h243)
        settle();
        // Good resistor, a non-init calibration that must not touch the field,
        // an assembly fault, then a calibration that must be ignored.
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_sys);
            zqSense <= (s == 2) ? 2'h1 : (s == 1) ? 2'h2 : 2'h3;
            repeat (3) @(posedge clk_sys);
            wr(8'h0a, (s == 1) ? 8'hab : lpddr2_mr_pkg::ZQ_INIT_CODE);
            `CHK(zqCalBusy, s < 3)
            settle();
            rd(8'h00, (s < 2) ? 8'h1a : 8'h0a);
            `CHK(factoryTrim, s > 1)
        end
        for (i = 0; i < 100 && expBeats.size() > 0; i++) @(negedge clk_sys);
        `CHK(expBeats.size(), 0)
        end_sim();
    end
endmodule : tb
